/* File: rtl/dcps_pkg.sv */
package dcps_pkg;

	// Register byte offsets on the AXI4-Lite slave.
	localparam logic [7:0] GEN_CTRL_OFS = 8'h00;
	localparam logic [7:0] TX_CTRL_OFS = 8'h04;
	localparam logic [7:0] GEN_RESET_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;

	// General control field positions.
	localparam int GEN_MOD_EN_BIT = 0;
	localparam int GEN_BIAS_EN_BIT = 4;
	localparam int GEN_LO_HALF_BIT = 6;

	// Register values after reset and forced values in direct mode.
	localparam logic [7:0] GEN_CTRL_RST = 8'h00;
	localparam logic [7:0] TX_CTRL_RST = 8'h00;
	localparam logic [7:0] GEN_DIRECT_ON = 8'h11;

	// Writable bits; the rest are reserved and read as zero.
	localparam logic [7:0] GEN_CTRL_MASK = 8'h51;
	localparam logic [7:0] TX_CTRL_MASK = 8'h0F;

	// Synchronised pin lanes and their values during reset.
	localparam int PIN_SER_DIS = 0;
	localparam int PIN_RANGE_LO = 1;
	localparam int PIN_RANGE_HI = 2;
	localparam int PIN_SLEEP_N = 3;
	localparam int PIN_DIVIDER = 4;
	localparam int PIN_COUNT = 5;
	localparam logic [4:0] PIN_RST = 5'h01;

	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic {
		DCPS_SERIAL,
		DCPS_DIRECT
	} dcps_mode_type;

endpackage

/* File: rtl/dcps_pin_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface dcps_pin_if #(
	parameter int WIDTH = 5
);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] clean;

	modport sync (
		input raw,
		output clean
	);
	modport user (
		output raw,
		input clean
	);
endinterface

`default_nettype wire

/* File: rtl/dcps_pin_sync.sv */
`timescale 1ns/100ps
`default_nettype none

module dcps_pin_sync #(
	parameter int WIDTH = 5,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Pins in, settled levels out.
	dcps_pin_if.sync pins
);
	logic [WIDTH-1:0] s1_r, s2_r, s3_r, clean_r;
	logic [WIDTH-1:0] clean_nxt;

	// A change is only believed once the second and third stages agree.
	always_comb begin
		clean_nxt = clean_r;
		for (int i = 0; i < WIDTH; i++) begin
			if (s2_r[i] == s3_r[i]) begin
				clean_nxt[i] = s3_r[i];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			clean_r <= RST_VAL;
		end else begin
			s1_r <= pins.raw;
			s2_r <= s1_r;
			s3_r <= s2_r;
			clean_r <= clean_nxt;
		end
	end

	assign pins.clean = clean_r;
endmodule

`default_nettype wire

/* File: rtl/dcps_top.sv */
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Serial-disable low turns the four shared pins into direct-control inputs.
// - Serial-disable low with the sleep pin high enables bias and modulator as if both bits were set.
// - While serial-disable is low, registers stay reset except the two enables.
// - In direct mode the first range pin is the low frequency-setting bit.
// - In direct mode the second range pin is the high frequency-setting bit.
// - In direct mode a low sleep pin forces low power; outside must drive it.
// - In direct mode divider pin low gives LO/2, high gives LO/4.
// - The serial-disable pin is weakly pulled high, selecting serial mode.
// - Reset clears every register bit and leaves the device in power-save.
// - Serial disabled with sleep pin low holds the registers as after reset and the device in power-save.
// - Under register control bit six one divides by two, zero by four.
module dcps_top (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address and data.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response.
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read.
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Mode pin and shared pins.
	input wire logic serial_disable_n,
	output logic serial_disable_pull_en,
	input wire logic lo_range_sel_low,
	input wire logic lo_range_sel_high,
	input wire logic direct_sleep_n,
	input wire logic lo_divider_pin_in,
	output logic lo_divider_pin_out,
	output logic lo_divider_pin_oe_n,
	// Settings to the analogue sections.
	output logic bias_enable,
	output logic modulator_enable,
	output logic lo_half_select,
	output logic [3:0] lo_range,
	output logic power_save,
	output logic direct_mode
);
	dcps_pin_if #(.WIDTH(dcps_pkg::PIN_COUNT)) pin_bus ();

	assign pin_bus.raw = {lo_divider_pin_in, direct_sleep_n,
		lo_range_sel_high, lo_range_sel_low, serial_disable_n};

	dcps_pin_sync #(
		.WIDTH(dcps_pkg::PIN_COUNT),
		.RST_VAL(dcps_pkg::PIN_RST)
	) u_sync (
		.aclk(aclk),
		.aresetn(aresetn),
		.pins(pin_bus.sync)
	);

	logic [4:0] pin_q;
	assign pin_q = pin_bus.clean;

	dcps_pkg::dcps_mode_type mode;
	assign mode = pin_q[dcps_pkg::PIN_SER_DIS] ? dcps_pkg::DCPS_SERIAL :
		dcps_pkg::DCPS_DIRECT;

	// Register state.
	logic [7:0] gen_ctrl_r, gen_ctrl_nxt;
	logic [7:0] tx_ctrl_r, tx_ctrl_nxt;
	// Bus state.
	logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
	logic [7:0] wa_r, wa_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic wstb_r, wstb_nxt;
	logic awready_r, awready_nxt, wready_r, wready_nxt;
	logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	// Output state.
	logic bias_r, bias_nxt, mod_r, mod_nxt, half_r, half_nxt;
	logic [3:0] range_r, range_nxt;
	logic psave_r, psave_nxt, direct_r, direct_nxt;
	logic pull_r, div_oe_n_r, div_oe_n_nxt;

	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == dcps_pkg::GEN_CTRL_OFS) ||
			(a == dcps_pkg::TX_CTRL_OFS) ||
			(a == dcps_pkg::GEN_RESET_OFS) ||
			(a == dcps_pkg::STATUS_OFS);
	endfunction

	// Bus handshakes; address and data may arrive in either order.
	always_comb begin
		logic do_wr;
		do_wr = 1'b0;
		aw_got_nxt = aw_got_r;
		w_got_nxt = w_got_r;
		wa_nxt = wa_r;
		wd_nxt = wd_r;
		wstb_nxt = wstb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		rvalid_nxt = rvalid_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		if (s_axi_awvalid && awready_r) begin
			aw_got_nxt = 1'b1;
			wa_nxt = {s_axi_awaddr[7:2], 2'b00};
		end
		if (s_axi_wvalid && wready_r) begin
			w_got_nxt = 1'b1;
			wd_nxt = s_axi_wdata;
			wstb_nxt = s_axi_wstrb[0];
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
		if (aw_got_r && w_got_r && !bvalid_r) begin
			do_wr = 1'b1;
			aw_got_nxt = 1'b0;
			w_got_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = is_mapped(wa_r) ? dcps_pkg::RESP_OKAY :
				dcps_pkg::RESP_SLVERR;
		end
		awready_nxt = !aw_got_nxt && !bvalid_nxt;
		wready_nxt = !w_got_nxt && !bvalid_nxt;
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (s_axi_arvalid && arready_r) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = dcps_pkg::RESP_OKAY;
			rdata_nxt = 32'h0000_0000;
			unique case ({s_axi_araddr[7:2], 2'b00})
			dcps_pkg::GEN_CTRL_OFS: rdata_nxt[7:0] = gen_ctrl_r;
			dcps_pkg::TX_CTRL_OFS: rdata_nxt[7:0] = tx_ctrl_r;
			dcps_pkg::STATUS_OFS: rdata_nxt[6:0] = {pin_q, psave_r,
				direct_r};
			default: rresp_nxt = is_mapped({s_axi_araddr[7:2], 2'b00}) ?
				dcps_pkg::RESP_OKAY : dcps_pkg::RESP_SLVERR;
			endcase
		end
		arready_nxt = !rvalid_nxt;

		// Register file: writes steer it only under serial control.
		gen_ctrl_nxt = gen_ctrl_r;
		tx_ctrl_nxt = tx_ctrl_r;
		if (do_wr && wstb_r) begin
			unique case (wa_r)
			dcps_pkg::GEN_CTRL_OFS: gen_ctrl_nxt = wd_r[7:0] &
				dcps_pkg::GEN_CTRL_MASK;
			dcps_pkg::TX_CTRL_OFS: tx_ctrl_nxt = wd_r[7:0] &
				dcps_pkg::TX_CTRL_MASK;
			default: ;
			endcase
		end
		if (do_wr && wa_r == dcps_pkg::GEN_RESET_OFS) begin
			gen_ctrl_nxt = dcps_pkg::GEN_CTRL_RST;
			tx_ctrl_nxt = dcps_pkg::TX_CTRL_RST;
		end
		if (mode == dcps_pkg::DCPS_DIRECT) begin
			// Held, not merely forced at the outputs, so that leaving
			// direct mode starts from reset values except the two enables.
			tx_ctrl_nxt = dcps_pkg::TX_CTRL_RST;
			gen_ctrl_nxt = pin_q[dcps_pkg::PIN_SLEEP_N] ?
				dcps_pkg::GEN_DIRECT_ON :
				dcps_pkg::GEN_CTRL_RST;
		end
	end

	// Effective settings seen by the analogue sections.
	always_comb begin
		bias_nxt = gen_ctrl_r[dcps_pkg::GEN_BIAS_EN_BIT];
		mod_nxt = gen_ctrl_r[dcps_pkg::GEN_MOD_EN_BIT];
		psave_nxt = !bias_nxt && !mod_nxt;
		direct_nxt = (mode == dcps_pkg::DCPS_DIRECT);
		// Outside reset, the divider pin only turns into an input in direct mode.
		div_oe_n_nxt = direct_nxt;
		if (direct_nxt) begin
			half_nxt = !pin_q[dcps_pkg::PIN_DIVIDER];
			range_nxt = {2'b00, pin_q[dcps_pkg::PIN_RANGE_HI],
				pin_q[dcps_pkg::PIN_RANGE_LO]};
			psave_nxt = !pin_q[dcps_pkg::PIN_SLEEP_N];
		end else begin
			half_nxt = gen_ctrl_r[dcps_pkg::GEN_LO_HALF_BIT];
			range_nxt = tx_ctrl_r[3:0];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			gen_ctrl_r <= dcps_pkg::GEN_CTRL_RST;
			tx_ctrl_r <= dcps_pkg::TX_CTRL_RST;
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			wa_r <= 8'h00;
			wd_r <= 32'h0000_0000;
			wstb_r <= 1'b0;
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= dcps_pkg::RESP_OKAY;
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rresp_r <= dcps_pkg::RESP_OKAY;
			rdata_r <= 32'h0000_0000;
			bias_r <= 1'b0;
			mod_r <= 1'b0;
			half_r <= 1'b0;
			range_r <= 4'h0;
			psave_r <= 1'b1;
			direct_r <= 1'b0;
			div_oe_n_r <= 1'b1;
			pull_r <= 1'b1;
		end else begin
			gen_ctrl_r <= gen_ctrl_nxt;
			tx_ctrl_r <= tx_ctrl_nxt;
			aw_got_r <= aw_got_nxt;
			w_got_r <= w_got_nxt;
			wa_r <= wa_nxt;
			wd_r <= wd_nxt;
			wstb_r <= wstb_nxt;
			awready_r <= awready_nxt;
			wready_r <= wready_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			arready_r <= arready_nxt;
			rvalid_r <= rvalid_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
			bias_r <= bias_nxt;
			mod_r <= mod_nxt;
			half_r <= half_nxt;
			range_r <= range_nxt;
			psave_r <= psave_nxt;
			direct_r <= direct_nxt;
			div_oe_n_r <= div_oe_n_nxt;
			pull_r <= 1'b1;
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rresp = rresp_r;
	assign s_axi_rdata = rdata_r;
	assign serial_disable_pull_en = pull_r;
	// Serial read-back framing is outside this block; the pin idles low.
	assign lo_divider_pin_out = 1'b0;
	assign lo_divider_pin_oe_n = div_oe_n_r;
	assign bias_enable = bias_r;
	assign modulator_enable = mod_r;
	assign lo_half_select = half_r;
	assign lo_range = range_r;
	assign power_save = psave_r;
	assign direct_mode = direct_r;
endmodule

`default_nettype wire

/* File: verif/dcps_pin_host.sv */
`timescale 1ns/100ps
`default_nettype none

module dcps_pin_host (
	// Commands from the bench.
	input wire logic direct_req,
	input wire logic [1:0] range_req,
	input wire logic sleep_req_n,
	input wire logic div_req,
	// Divider pin as the device drives it.
	input wire logic lo_divider_pin_out,
	input wire logic lo_divider_pin_oe_n,
	// Pin levels seen by the device.
	output logic serial_disable_n,
	output logic lo_range_sel_low,
	output logic lo_range_sel_high,
	output logic direct_sleep_n,
	output logic lo_divider_pin_in
);
	// A released mode pin reads high through the pull-up.
	assign serial_disable_n = !direct_req;
	assign lo_range_sel_low = range_req[0];
	assign lo_range_sel_high = range_req[1];
	// The sleep pin has no pull, so the host never leaves it floating.
	assign direct_sleep_n = sleep_req_n;
	assign lo_divider_pin_in = lo_divider_pin_oe_n ? div_req
		: lo_divider_pin_out;
endmodule

`default_nettype wire

/* File: verif/dcps_top_assertions.sv */
`timescale 1ns/100ps
`default_nettype none

module dcps_top_assertions (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Read handshakes.
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Pins and settings.
	input wire logic serial_disable_n,
	input wire logic serial_disable_pull_en,
	input wire logic lo_range_sel_low,
	input wire logic lo_range_sel_high,
	input wire logic direct_sleep_n,
	input wire logic lo_divider_pin_in,
	input wire logic lo_divider_pin_oe_n,
	input wire logic bias_enable,
	input wire logic modulator_enable,
	input wire logic lo_half_select,
	input wire logic [3:0] lo_range,
	input wire logic power_save,
	input wire logic direct_mode
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Eight quiet edges cover the synchroniser and output flops.
	sequence pins_still;
		$stable({serial_disable_n, lo_range_sel_low, lo_range_sel_high,
			direct_sleep_n, lo_divider_pin_in})[*8];
	endsequence
	sequence direct_still;
		pins_still ##0 !serial_disable_n;
	endsequence
	a_pull_always: assert property (serial_disable_pull_en)
		else $error("pull-up enable dropped");
	a_direct_pins: assert property (direct_still |->
		direct_mode && lo_divider_pin_oe_n
		&& lo_range == {2'h0, lo_range_sel_high, lo_range_sel_low}
		&& (!direct_sleep_n || lo_half_select == !lo_divider_pin_in))
		else $error("direct pin mapping wrong");
	a_direct_awake: assert property (direct_still ##0 direct_sleep_n |->
		bias_enable && modulator_enable && !power_save)
		else $error("direct enables not forced");
	a_direct_asleep: assert property (direct_still ##0 !direct_sleep_n |->
		power_save && !bias_enable && !modulator_enable)
		else $error("sleep pin ignored");
	a_serial_ignore: assert property (pins_still ##0 serial_disable_n |->
		!direct_mode && !lo_divider_pin_oe_n
		&& power_save == !(bias_enable || modulator_enable))
		else $error("serial mode state wrong");
	a_reset_vals: assert property ($rose(aresetn) |-> power_save
		&& !bias_enable && !modulator_enable && lo_range == 4'h0)
		else $error("reset values wrong");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=>
		s_axi_rvalid && !s_axi_arready)
		else $error("read not answered");
	a_read_done: assert property (s_axi_rvalid && s_axi_rready |=>
		!s_axi_rvalid && s_axi_arready)
		else $error("read not closed");
endmodule

bind dcps_top dcps_top_assertions chk_i (.*);

`default_nettype wire

/* File: verif/test_direct_control_pin_select.sv */
`timescale 1ns/100ps
`default_nettype none

module test_direct_control_pin_select;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, serial_disable_n;
	logic serial_disable_pull_en, lo_range_sel_low, lo_range_sel_high;
	logic direct_sleep_n, lo_divider_pin_in, lo_divider_pin_out;
	logic lo_divider_pin_oe_n, bias_enable, modulator_enable, lo_half_select;
	logic power_save, direct_mode, direct_req, sleep_req_n, div_req;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb, lo_range;
	logic [1:0] s_axi_bresp, s_axi_rresp, range_req;
	int n_mismatch, check_count, cyc;
	wire logic [9:0] st = {direct_mode, power_save, bias_enable,
		modulator_enable, lo_half_select, lo_divider_pin_oe_n, lo_range};

	dcps_top uut (.*);
	dcps_pin_host host (.*);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			if (s_axi_bvalid) break;
		end
		chk(s_axi_bresp, er);
		s_axi_bready <= 1'h0;
		@(posedge aclk);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) break;
		end
		chk(s_axi_rdata, ed);
		chk(s_axi_rresp, er);
		s_axi_rready <= 1'h0;
		@(posedge aclk);
	endtask
	// Pin changes need several edges to cross the synchroniser.
	task automatic settle;
		repeat (10) @(posedge aclk);
	endtask
	task automatic finish_test;
		$display("mismatches %0d checks %0d", n_mismatch, check_count);
		if (n_mismatch == 0 && check_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		aclk = 1'h0;
		forever #50 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			finish_test();
		end
	end

	initial begin
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
		{s_axi_rready, direct_req, div_req, aresetn} = 4'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'h1;
		range_req = 2'h0;
		sleep_req_n = 1'h1;
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		settle();
		chk(st, 10'h100);
		chk({serial_disable_pull_en, lo_divider_pin_out}, 2'h2);
		rdc(8'h00, 8'h00, 2'h0);
		rdc(8'h0C, 8'h26, 2'h0);
		wr(8'h00, 8'hFF, 2'h0);
		rdc(8'h00, 8'h51, 2'h0);
		wr(8'h04, 8'hFF, 2'h0);
		rdc(8'h04, 8'h0F, 2'h0);
		range_req <= 2'h3;
		sleep_req_n <= 1'h0;
		div_req <= 1'h1;
		settle();
		chk(st, 10'h0EF);
		wr(8'h00, 8'h11, 2'h0);
		settle();
		chk(st, 10'h0CF);
		wr(8'h10, 8'h01, 2'h2);
		rdc(8'h10, 8'h00, 2'h2);
		wr(8'h08, 8'h00, 2'h0);
		settle();
		chk(st, 10'h100);
		rdc(8'h04, 8'h00, 2'h0);
		rdc(8'h08, 8'h00, 2'h0);
		s_axi_wstrb <= 4'h0;
		wr(8'h04, 8'h0F, 2'h0);
		s_axi_wstrb <= 4'h1;
		rdc(8'h04, 8'h00, 2'h0);
		sleep_req_n <= 1'h1;
		direct_req <= 1'h1;
		for (int i = 0; i < 8; i++) begin
			range_req <= i[1:0];
			div_req <= i[2];
			settle();
			chk(st, {4'hB, ~i[2], 3'h4, i[1:0]});
		end
		rdc(8'h0C, 8'h79, 2'h0);
		wr(8'h00, 8'h40, 2'h0);
		rdc(8'h00, 8'h11, 2'h0);
		rdc(8'h04, 8'h00, 2'h0);
		sleep_req_n <= 1'h0;
		settle();
		chk(st, 10'h313);
		rdc(8'h00, 8'h00, 2'h0);
		direct_req <= 1'h0;
		sleep_req_n <= 1'h1;
		settle();
		chk({direct_mode, lo_divider_pin_oe_n}, 2'h0);
		wr(8'h00, 8'h51, 2'h0);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		settle();
		chk(st, 10'h100);
		rdc(8'h00, 8'h00, 2'h0);
		finish_test();
	end
endmodule

`default_nettype wire
